/* testbench.sv */
// Self-checking bench of the two-wire slave and its APB registers.
`timescale 1ns/1ps
`include "tws_params.svh"
module testbench;
	import tws_pkg::*;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	tws_word_t pwdata = 32'h0;
	tws_word_t prdata;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, wake, byte_ev;
	logic m_scl, m_sda, scl_w, sda_w, e, ak;
	logic [7:0] q, a, d, g;
	logic [7:0] rv [5] = '{8'h00, 8'h81, 8'h00, 8'h00, 8'h00};
	logic [7:0] model [$];
	int mismatches = 0;
	int num_checks = 0;
	int wakes = 0;
	int lat [4];
	int n0;
	integer seed = 32'hba991ee1;
	// Pull-ups win wherever nobody pulls low.
	assign scl_w = !((scl_oe && !scl_o) || m_scl);
	assign sda_w = !((sda_oe && !sda_o) || m_sda);
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (wake === 1'b1) wakes <= wakes + 1;
	tws_slave i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .wake_o(wake), .byte_event_o(byte_ev));
	tws_master i_m (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge core_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h0, wd};
		@(posedge core_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			$display("[ERR] %0t register bus never answered", $time);
		end
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] x);
		apb(1'b0, ad, 8'h00);
		chk(q & m, x);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		wt(6);
		resetn_i <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rchk(8'(4 * i), 8'hFF, rv[i]);
		end
		rchk(8'h14, 8'hFF, 8'h00);
		chk({7'h0, e}, 8'h01);
		apb(1'b1, `TWS_OFF_CTRL0, 8'hFF);
		rchk(`TWS_OFF_CTRL0, 8'hFF, 8'h0E);
		apb(1'b1, `TWS_OFF_ADDR, 8'hFF);
		rchk(`TWS_OFF_ADDR, 8'hFF, 8'hFE);
		apb(1'b1, `TWS_OFF_STAT, 8'hFF);
		rchk(`TWS_OFF_STAT, 8'hFF, 8'h9B);
		apb(1'b1, `TWS_OFF_CTRL0, 8'h00);
		apb(1'b1, `TWS_OFF_STAT, 8'h00);
		i_m.start();
		i_m.wr(8'hFE, ak);
		chk({7'h0, ak}, 8'h01);
		rchk(`TWS_OFF_STAT, 8'hFF, 8'h81);
		i_m.stop();
		$display("test registers done");
		// Stop to completion pulse latency per debounce code, relative to no debounce.
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `TWS_OFF_CTRL0, 8'(4 * k + 2));
			wt(10);
			i_m.start();
			fork
				i_m.stop();
				begin
					@(posedge sda_w);
					n0 = 0;
					while (byte_ev !== 1'b1 && n0 < 40) begin
						@(negedge core_clk_i);
						n0++;
					end
					lat[k] = n0;
				end
			join
			chk(8'(lat[k] - lat[0]), (k == 0) ? 8'h00 : ((k == 1) ? 8'h02 : 8'h04));
		end
		$display("test debounce done");
		// Transfers run without debounce: at this link rate a filtered slave cannot answer within one low phase.
		for (int k = 0; k < 4; k++) begin
			a = 8'($random(seed)) & 8'hFE;
			apb(1'b1, `TWS_OFF_ADDR, a);
			apb(1'b1, `TWS_OFF_CTRL0, 8'h02);
			apb(1'b1, `TWS_OFF_STAT, 8'h02);
			wt(10);
			wakes = 0;
			i_m.start();
			i_m.wr(a, ak);
			chk({7'h0, ak}, 8'h00);
			wt(20);
			rchk(`TWS_OFF_STAT, 8'hFF, 8'hE3);
			chk(8'(wakes), 8'h01);
			for (int j = 0; j < 2; j++) begin
				d = 8'($random(seed));
				model.push_back(d);
				apb(1'b1, `TWS_OFF_STAT, 8'(8 * j));
				fork
					i_m.wr(d, ak);
					begin
						wt(20);
						apb(1'b0, `TWS_OFF_DATA, 8'h00);
						if (j == 1) chk(q, model.pop_front());
						wt(30);
						rchk(`TWS_OFF_STAT, 8'h80, 8'h00);
					end
				join
				chk({7'h0, ak}, 8'(j));
			end
			wt(20);
			rchk(`TWS_OFF_STAT, 8'h80, 8'h80);
			apb(1'b0, `TWS_OFF_DATA, 8'h00);
			chk(q, model.pop_front());
			apb(1'b1, `TWS_OFF_STAT, 8'h00);
			i_m.stop();
			wt(20);
			rchk(`TWS_OFF_STAT, 8'hA0, 8'h80);
			$display("test receive %0d done", k);
		end
		apb(1'b1, `TWS_OFF_STAT, 8'h18);
		i_m.start();
		i_m.wr(a ^ 8'h02, ak);
		chk({7'h0, ak}, 8'h01);
		rchk(`TWS_OFF_STAT, 8'h60, 8'h20);
		apb(1'b1, `TWS_OFF_CTRL0, 8'h00);
		apb(1'b1, `TWS_OFF_CTRL0, 8'h02);
		rchk(`TWS_OFF_STAT, 8'hFF, 8'h99);
		i_m.stop();
		$display("test mismatch done");
		apb(1'b1, `TWS_OFF_STAT, 8'h00);
		wt(10);
		i_m.start();
		i_m.wr(a | 8'h01, ak);
		chk({7'h0, ak}, 8'h00);
		wt(20);
		rchk(`TWS_OFF_STAT, 8'hFF, 8'hE5);
		apb(1'b1, `TWS_OFF_STAT, 8'h10);
		for (int j = 0; j < 2; j++) begin
			d = 8'($random(seed));
			fork
				i_m.rd(g, j[0]);
				begin
					wt(20);
					apb(1'b1, `TWS_OFF_DATA, d);
					wt(30);
					rchk(`TWS_OFF_STAT, 8'h80, 8'h00);
				end
			join
			chk(g, d);
			wt(20);
			rchk(`TWS_OFF_STAT, 8'h81, 8'h80 | 8'(j));
			chk({7'h0, sda_oe}, 8'h00);
		end
		i_m.stop();
		wt(20);
		rchk(`TWS_OFF_STAT, 8'hA0, 8'h80);
		$display("test transmit done");
		summarize();
	end
	// A hung bus or stuck stretch ends the run here.
	initial begin
		#400000;
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
endmodule

/* tws_master.sv */
// Behavioural two-wire bus master for the far side of the slave.
`timescale 1ns/1ps
module tws_master (
	// Resolved bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	// Open-drain pulls
	output logic scl_low_o,
	output logic sda_low_o
);
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	// The slave may stretch a released clock, so the wait is bounded.
	task automatic rise();
		int n;
		n = 0;
		scl_low_o = 1'b0;
		while (scl_i !== 1'b1 && n < 9999) begin
			#10;
			n++;
		end
		#62.5;
	endtask
	// Data moves well inside the low phase so no false start or stop is seen.
	task automatic put(input logic b);
		#30;
		sda_low_o = !b;
		#32.5;
		rise();
		scl_low_o = 1'b1;
	endtask
	task automatic start();
		sda_low_o = 1'b1;
		#62.5;
		scl_low_o = 1'b1;
	endtask
	task automatic stop();
		#30;
		sda_low_o = 1'b1;
		#32.5;
		rise();
		sda_low_o = 1'b0;
		#62.5;
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			put(b[i]);
		end
		#30;
		sda_low_o = 1'b0;
		#32.5;
		rise();
		ack = sda_i;
		scl_low_o = 1'b1;
	endtask
	task automatic rd(output logic [7:0] b, input logic nack);
		sda_low_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#62.5;
			rise();
			b[i] = sda_i;
			scl_low_o = 1'b1;
		end
		put(nack);
	endtask
endmodule

/* tws_params.svh */
// Offsets, field positions, reset values and debounce counts of the two-wire slave.
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_OFF_CTRL0 8'h00
`define TWS_OFF_STAT 8'h04
`define TWS_OFF_DATA 8'h08
`define TWS_OFF_ADDR 8'h0C
`define TWS_OFF_TOC 8'h10
`define TWS_IDX_CTRL0 3'h0
`define TWS_IDX_STAT 3'h1
`define TWS_IDX_DATA 3'h2
`define TWS_IDX_ADDR 3'h3
`define TWS_IDX_TOC 3'h4
`define TWS_IDX_NONE 3'h7
`define TWS_C0_EN 1
`define TWS_C0_DEB_LO 2
`define TWS_C0_DEB_HI 3
`define TWS_ST_ACK_RECEIVED_FLAG 0
`define TWS_ST_MATCH_WAKE_ENABLE 1
`define TWS_ST_ACK_TO_SEND 3
`define TWS_ST_HTX 4
`define TWS_CTRL0_RST 8'h00
`define TWS_STAT_RST 8'h81
`define TWS_ADDR_RST 8'h00
`define TWS_TOC_RST 8'h00
`define TWS_DEB_NONE 3'h0
`define TWS_DEB_TWO 3'h2
`define TWS_DEB_FOUR 3'h4
`define TWS_BITS 4'h8
`define TWS_ACKBIT 4'h9
`endif

/* tws_pkg.sv */
// Types shared by the two-wire slave.
package tws_pkg;
	typedef logic [31:0] tws_word_t;
	typedef logic [7:0] tws_byte_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_HOLD, ST_RX, ST_RACK, ST_TX, ST_TACK, ST_WAIT
	} tws_state_t;
endpackage

/* tws_slave.sv */
// Two-wire bus slave with its APB register file.
//
// Contract
// - Every bus byte passes through the one data buffer, both directions; the code does not store the address byte in it.
// - Own 7-bit address sits in bits 7..1; bit 0 reads zero.
// - Debounce code 00 none, 01 two clocks, 10 and 11 four clocks.
// - Enable low removes the bus function; enable high operates.
// - Enable rising keeps role and ack bits, resets the status flags.
// - Completion flag low during a byte, set when eight bits finish; the code sets it for a transmitted byte on the rise of clock nine.
// - Start clears completion; byte sets; data read clears; stop sets.
// - Address match flag set on matching address, low otherwise.
// - Busy set by start, cleared by stop.
// - Transmit select 0 makes a receiver, 1 a transmitter.
// - After eight received bits the ack bit is driven on clock nine.
// - Master read/write bit captured: one means slave transmits.
// - Wake enable lets an address match wake; software clears it.
// - Received ack flag is zero when master acknowledged, else one.
// - Transmitter sends while acked, then releases data for a stop.
// - Control zero bits 7..4 and bit 0 read zero.
// - Address arrives MSB first after start, read/write bit eighth.
// - A matching address is acknowledged low on the ninth bit.
// - After a match the clock is held until data write or read.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_slave (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire tws_pkg::tws_word_t pwdata_i,
	output tws_pkg::tws_word_t prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Two-wire pins, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Events to the system
	output logic wake_o,
	output logic byte_event_o
);
	import tws_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		case (a)
			`TWS_OFF_CTRL0: reg_idx = `TWS_IDX_CTRL0;
			`TWS_OFF_STAT: reg_idx = `TWS_IDX_STAT;
			`TWS_OFF_DATA: reg_idx = `TWS_IDX_DATA;
			`TWS_OFF_ADDR: reg_idx = `TWS_IDX_ADDR;
			`TWS_OFF_TOC: reg_idx = `TWS_IDX_TOC;
			default: reg_idx = `TWS_IDX_NONE;
		endcase
	endfunction

	function automatic logic [2:0] deb_need(input logic [1:0] sel);
		case (sel)
			2'h0: deb_need = `TWS_DEB_NONE;
			2'h1: deb_need = `TWS_DEB_TWO;
			default: deb_need = `TWS_DEB_FOUR;
		endcase
	endfunction

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [1:0] deb_sel;
	logic en, en_q;
	logic transmit_select, ack_to_send, match_wake_enable;
	logic byte_complete_flag, address_match_flag, bus_busy_flag, master_read_flag, ack_received_flag;
	logic [6:0] own_addr;
	tws_byte_t toc;
	tws_byte_t data_buf;
	tws_byte_t shreg;
	logic [3:0] cnt;
	tws_state_t state;
	logic [1:0] s1, s2, s3, raw, filt, prev;
	logic [2:0] dcnt [2];

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic setup, acc, wr, rd, wr_data, rd_data;
	logic [2:0] idx;
	assign idx = reg_idx(paddr_i);
	assign setup = psel_i & ~penable_i;
	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign rd = acc & ~pwrite_i;
	assign wr_data = wr & (idx == `TWS_IDX_DATA);
	assign rd_data = rd & (idx == `TWS_IDX_DATA);
	assign pready_o = 1'b1;
	assign pslverr_o = acc & (idx == `TWS_IDX_NONE);

	// Read data is latched in the setup cycle so the zero-wait access sees a flop.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup) begin
			case (idx)
				`TWS_IDX_CTRL0: prdata_o <= {24'h00_0000, 4'h0, deb_sel, en, 1'b0};
				`TWS_IDX_STAT: prdata_o <= {24'h00_0000, byte_complete_flag, address_match_flag, bus_busy_flag, transmit_select, ack_to_send, master_read_flag, match_wake_enable, ack_received_flag};
				`TWS_IDX_DATA: prdata_o <= {24'h00_0000, data_buf};
				`TWS_IDX_ADDR: prdata_o <= {24'h00_0000, own_addr, 1'b0};
				`TWS_IDX_TOC: prdata_o <= {24'h00_0000, toc[7], 1'b0, toc[5:0]};
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// Control bits; an enable rise leaves role and ack bits untouched.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			deb_sel <= 2'h0;
			en <= 1'b0;
			transmit_select <= 1'b0;
			ack_to_send <= 1'b0;
			match_wake_enable <= 1'b0;
			own_addr <= 7'h00;
			toc <= `TWS_TOC_RST;
		end else if (wr) begin
			case (idx)
				`TWS_IDX_CTRL0: begin
					deb_sel <= pwdata_i[`TWS_C0_DEB_HI:`TWS_C0_DEB_LO];
					en <= pwdata_i[`TWS_C0_EN];
				end
				`TWS_IDX_STAT: begin
					transmit_select <= pwdata_i[`TWS_ST_HTX];
					ack_to_send <= pwdata_i[`TWS_ST_ACK_TO_SEND];
					match_wake_enable <= pwdata_i[`TWS_ST_MATCH_WAKE_ENABLE];
				end
				`TWS_IDX_ADDR: own_addr <= pwdata_i[7:1];
				`TWS_IDX_TOC: toc <= pwdata_i[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en;
		end
	end

	// ----------------------------------------
	// Input synchronisers and debounce
	// ----------------------------------------
	// Bit 0 is the clock line, bit 1 the data line; idle bus reads high.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1 <= 2'h3;
			s2 <= 2'h3;
			s3 <= 2'h3;
		end else begin
			s1 <= {sda_i, scl_i};
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			raw <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (s2[i] == s3[i]) begin
					raw[i] <= s3[i];
				end
			end
		end
	end

	// A level must hold the selected number of clocks before it is believed.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			filt <= 2'h3;
			prev <= 2'h3;
			dcnt[0] <= 3'h0;
			dcnt[1] <= 3'h0;
		end else begin
			prev <= filt;
			for (int i = 0; i < 2; i++) begin
				if (raw[i] == filt[i]) begin
					dcnt[i] <= 3'h0;
				end else if (dcnt[i] >= deb_need(deb_sel)) begin
					filt[i] <= raw[i];
					dcnt[i] <= 3'h0;
				end else begin
					dcnt[i] <= dcnt[i] + 3'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Bus events
	// ----------------------------------------
	logic scl_rise, scl_fall, start_c, stop_c, act, bit8_fall;
	logic match_ev, rx_done, tx_ack, hcf_set, rel;
	assign scl_rise = filt[0] & ~prev[0];
	assign scl_fall = ~filt[0] & prev[0];
	assign start_c = en & prev[1] & ~filt[1] & filt[0] & prev[0];
	assign stop_c = en & ~prev[1] & filt[1] & filt[0] & prev[0];
	assign act = en & ~start_c & ~stop_c;
	assign bit8_fall = scl_fall & (cnt == `TWS_BITS);
	assign match_ev = act & (state == ST_ADDR) & bit8_fall & (shreg[7:1] == own_addr);
	assign rx_done = act & (state == ST_RX) & bit8_fall;
	assign tx_ack = act & (state == ST_TACK) & scl_rise;
	assign hcf_set = match_ev | rx_done | tx_ack | stop_c;
	assign rel = (state == ST_HOLD) & ((transmit_select & wr_data) | (~transmit_select & rd_data));

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Hardware sets win over the software read that clears completion.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			byte_complete_flag <= 1'b1;
			address_match_flag <= 1'b0;
			bus_busy_flag <= 1'b0;
			master_read_flag <= 1'b0;
			ack_received_flag <= 1'b1;
		end else if (en & ~en_q) begin
			byte_complete_flag <= 1'b1;
			address_match_flag <= 1'b0;
			bus_busy_flag <= 1'b0;
			master_read_flag <= 1'b0;
			ack_received_flag <= 1'b1;
		end else begin
			byte_complete_flag <= hcf_set | (byte_complete_flag & ~start_c & ~rd_data & ~rel);
			if (start_c) begin
				bus_busy_flag <= 1'b1;
				address_match_flag <= 1'b0;
			end else if (stop_c) begin
				bus_busy_flag <= 1'b0;
			end else if (match_ev) begin
				address_match_flag <= 1'b1;
			end
			if (match_ev) begin
				master_read_flag <= shreg[0];
			end
			if (tx_ack) begin
				ack_received_flag <= filt[1];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wake_o <= 1'b0;
			byte_event_o <= 1'b0;
		end else begin
			wake_o <= match_wake_enable & match_ev;
			byte_event_o <= hcf_set;
		end
	end

	// ----------------------------------------
	// Data buffer
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_buf <= 8'h00;
		end else if (rx_done) begin
			data_buf <= shreg;
		end else if (wr_data) begin
			data_buf <= pwdata_i[7:0];
		end
	end

	// ----------------------------------------
	// Transfer state machine
	// ----------------------------------------
	// The data line only ever changes while the clock is low, so no false start or stop is made.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
		end else if (!en) begin
			state <= ST_IDLE;
			cnt <= 4'h0;
		end else if (start_c) begin
			state <= ST_ADDR;
			cnt <= 4'h0;
		end else if (stop_c) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_ADDR: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], filt[1]};
						cnt <= cnt + 4'h1;
					end else if (bit8_fall) begin
						state <= match_ev ? ST_AACK : ST_WAIT;
					end
				end
				ST_AACK, ST_RACK: begin
					if (scl_rise) begin
						cnt <= `TWS_ACKBIT;
					end else if (scl_fall && cnt == `TWS_ACKBIT) begin
						state <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (rel) begin
						cnt <= 4'h0;
						if (transmit_select) begin
							state <= ST_TX;
							shreg <= pwdata_i[7:0];
						end else begin
							state <= ST_RX;
						end
					end
				end
				ST_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], filt[1]};
						cnt <= cnt + 4'h1;
					end else if (bit8_fall) begin
						state <= ST_RACK;
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						cnt <= cnt + 4'h1;
					end else if (bit8_fall) begin
						state <= ST_TACK;
					end else if (scl_fall) begin
						shreg <= {shreg[6:0], 1'b0};
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						cnt <= `TWS_ACKBIT;
					end else if (scl_fall && cnt == `TWS_ACKBIT) begin
						state <= ack_received_flag ? ST_WAIT : ST_HOLD;
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = (state == ST_HOLD);
	assign sda_oe_o = (state == ST_AACK) | ((state == ST_RACK) & ~ack_to_send) | ((state == ST_TX) & ~shreg[7]);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_START_BUSY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		start_c && !(en && !en_q) |=> bus_busy_flag && !byte_complete_flag && !address_match_flag)
		else $error("busy not set after start");
	AST_STOP_FREE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		stop_c && !(en && !en_q) |=> !bus_busy_flag && byte_complete_flag)
		else $error("busy not cleared after stop");
	AST_CTRL0_ZERO: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		rd && idx == `TWS_IDX_CTRL0 |-> prdata_o[7:4] == 4'h0 && !prdata_o[0] && prdata_o[1] == en)
		else $error("control zero reserved bits not zero");
	AST_ADDR_LSB: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		rd && idx == `TWS_IDX_ADDR |-> prdata_o[7:0] == {own_addr, 1'b0})
		else $error("own address readback wrong");
	AST_DIS_QUIET: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		!en |=> !scl_oe_o && !sda_oe_o)
		else $error("pins driven while disabled");
	AST_EN_FLAGS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$rose(en) |=> byte_complete_flag && !address_match_flag && !bus_busy_flag && !master_read_flag && ack_received_flag && $stable(transmit_select) && $stable(ack_to_send))
		else $error("flags not defaulted on enable");
	AST_READ_CLR: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		rd_data && !hcf_set && !(en && !en_q) |=> !byte_complete_flag)
		else $error("data read did not clear completion");
	AST_RX_ACK: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		state == ST_RACK |-> sda_oe_o == !ack_to_send && !scl_oe_o)
		else $error("ack bit not driven as programmed");
	AST_TX_RELEASE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		state == ST_TACK && scl_fall && cnt == `TWS_ACKBIT && ack_received_flag && en && !start_c && !stop_c
		|=> state == ST_WAIT ##1 !sda_oe_o)
		else $error("data line not released after no ack");
	AST_MATCH_HOLD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		match_ev |=> sda_oe_o && address_match_flag && state == ST_AACK)
		else $error("address match not acknowledged");
endmodule
